// ---- bench/cdc_conversion_sequencer_test.sv ----
`timescale 1ns/1ns
`default_nettype none
// --------------------------------------------------
// Sequencer bench: bus tasks and scenarios
// --------------------------------------------------
module cdc_conversion_sequencer_test import cdcseq_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic lf = 1'b0;
  logic hf = 1'b0;
  logic pin = 1'b0;
  logic cmd = 1'b0;
  logic [31:0] hrdata, result, rv;
  logic [15:0] mtime;
  logic [7:0] gain;
  logic [1:0] sw, cap;
  logic hready, hresp, req, done, eoc_d, eoc_r, dsp_done, int_n, rd_s, rd_d;
  int eoc_cnt, cyc, fails, cmp_count;
  time t0;
  time dur[3];
  time eoc_t[$];
  logic [3:0] step_q[$];
  logic [31:0] base[3] = '{32'h2196, 32'h2016, 32'h2096};
  cdcseq_top cdcseq_top_inst (.CLK_I(clk), .RESETN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .LF_OSC_I(lf), .HF_OSC_I(hf),
    .START_PIN_I(pin), .SIF_START_CMD_I(cmd), .SIF_READ_START_I(rd_s), .SIF_READ_DONE_I(rd_d),
    .MEAS_REQ_O(req), .PORT_SW_O(sw), .CAP_PORT_CHG_O(cap), .MEAS_DONE_I(done),
    .MEAS_TIME_I(mtime), .EOC_DSP_O(eoc_d), .EOC_RDC_O(eoc_r), .DSP_DONE_I(dsp_done),
    .RESULT_O(result), .GAIN_CORR_O(gain), .INTERRUPT_OUT_N_O(int_n));
  cdcseq_far_model cdcseq_far_model_inst (.clk_i(clk), .resetn_i(rstn), .meas_req_i(req),
    .cap_i(cap), .eoc_i(eoc_d), .int_n_i(int_n), .meas_done_o(done), .meas_time_o(mtime),
    .dsp_done_o(dsp_done), .rd_start_o(rd_s), .rd_done_o(rd_d));
  // Clocks: slow oscillator 8 cycles, fast one 6 cycles (slower than a quarter clock)
  always #20 clk = ~clk;
  always begin
    repeat (4) @(posedge clk);
    lf <= ~lf;
  end
  always begin
    repeat (3) @(posedge clk);
    hf <= ~hf;
  end
  // Log completions and step settings; cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (eoc_d === 1'b1) begin
      eoc_cnt++;
      eoc_t.push_back($time);
    end
    if (done === 1'b1 && req === 1'b1) step_q.push_back({sw, cap});
    if (cyc == 20000) begin
      fails++;
      final_report;
    end
  end
  task automatic final_report;
    if (fails == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask
  // Single AHB-Lite transfer; each phase held until ready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rv = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask
  task automatic clr;
    eoc_cnt = 0;
    eoc_t.delete();
    step_q.delete();
  endtask
  task automatic kick;
    @(posedge clk);
    cmd <= 1'b1;
    @(posedge clk);
    cmd <= 1'b0;
  endtask
  // One host-commanded conversion with the given control word
  task automatic run(input logic [31:0] ctrl);
    bus(1'b1, CDCS_ADDR_CTRL, ctrl);
    clr;
    t0 = $time;
    kick;
    while (eoc_cnt < 1) @(posedge clk);
    repeat (40) @(posedge clk);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    while (eoc_cnt < 2) @(posedge clk);
    chk({28'h0, step_q[0]}, 32'hd);
    chk({28'h0, step_q[1]}, 32'he);
    chk({28'h0, step_q[2]}, 32'h0);
    rd_chk(CDCS_ADDR_CTRL, 32'h10);
    rd_chk(CDCS_ADDR_INTDLY, 32'h40);
    bus(1'b1, CDCS_ADDR_CTRL, 32'h16);
    repeat (150) @(posedge clk);
    rd_chk(CDCS_ADDR_GAIN, 32'h0);
    bus(1'b1, CDCS_ADDR_GAIN, 32'h40);
    rd_chk(CDCS_ADDR_GAIN, 32'h40);
    chk({24'h0, gain}, 32'h40);
    chk({31'h0, hresp}, 32'h0);
    rd_chk(8'h40, 32'h0);
    // Two dummies and three averaged sequences; a second start mid-run is dropped
    bus(1'b1, CDCS_ADDR_AVG, 32'h3);
    bus(1'b1, CDCS_ADDR_CTRL, 32'h2016);
    clr;
    kick;
    repeat (10) @(posedge clk);
    kick;
    while (eoc_cnt < 1) @(posedge clk);
    repeat (200) @(posedge clk);
    chk(eoc_cnt, 32'h1);
    chk(step_q.size(), 32'hf);
    chk(result, 32'h840);
    rd_chk(CDCS_ADDR_RESULT, 32'h840);
    chk({31'h0, int_n}, 32'h1);
    bus(1'b1, CDCS_ADDR_AVG, 32'h0);
    // Cycle base: fast undivided, slow oscillator, fast divided by four
    for (int i = 0; i < 3; i++) begin
      run(base[i]);
      dur[i] = eoc_t[0] - t0;
    end
    chk({31'h0, dur[0] < dur[1] && dur[1] < dur[2]}, 32'h1);
    run(32'h7e);
    chk({28'h0, step_q[0]}, 32'h5);
    chk({28'h0, step_q[1]}, 32'ha);
    chk({30'h0, step_q[2][1:0]}, 32'h3);
    chk({28'h0, step_q[3]}, 32'h0);
    run(32'h76);
    chk({28'h0, step_q[0]}, 32'hd);
    // Undefined source never starts; pin source does
    bus(1'b1, CDCS_ADDR_CTRL, 32'h14);
    clr;
    kick;
    repeat (100) @(posedge clk);
    chk(eoc_cnt, 32'h0);
    bus(1'b1, CDCS_ADDR_CTRL, 32'h15);
    pin <= 1'b1;
    repeat (4) @(posedge clk);
    pin <= 1'b0;
    while (eoc_cnt < 1) @(posedge clk);
    repeat (60) @(posedge clk);
    // Read triggered: idle until commanded, then each finished read restarts
    bus(1'b1, CDCS_ADDR_CTRL, 32'h11);
    clr;
    repeat (100) @(posedge clk);
    chk(eoc_cnt, 32'h0);
    bus(1'b1, CDCS_ADDR_CMD, 32'h1);
    while (eoc_cnt < 2) @(posedge clk);
    bus(1'b1, CDCS_ADDR_CTRL, 32'h16);
    repeat (200) @(posedge clk);
    // Timer source: completions spaced by 2 * 10 slow periods of 320 ns
    bus(1'b1, CDCS_ADDR_PERIOD, 32'ha);
    rd_chk(CDCS_ADDR_PERIOD, 32'ha);
    bus(1'b1, CDCS_ADDR_CTRL, 32'h12);
    clr;
    while (eoc_cnt < 3) @(posedge clk);
    chk(32'(eoc_t[2] - eoc_t[1]), 32'd6400);
    final_report;
  end
endmodule // cdc_conversion_sequencer_test
`default_nettype wire

// ---- bench/cdcseq_far_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// --------------------------------------------------
// Front end, signal processor and host reader
// --------------------------------------------------
module cdcseq_far_model (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic meas_req_i,
  input wire logic [1:0] cap_i,
  input wire logic eoc_i,
  input wire logic int_n_i,
  output logic meas_done_o,
  output logic [15:0] meas_time_o,
  output logic dsp_done_o,
  output logic rd_start_o,
  output logic rd_done_o
);
  logic [2:0] fe_cnt;
  logic [1:0] dsp_q;
  logic [3:0] host_q;
  logic int_n_q;
  // Front end answers a request after four cycles; time depends on charged ports
  always_ff @(posedge clk_i) begin
    meas_done_o <= 1'b0;
    meas_time_o <= ~meas_time_o; // Stale time toggles so it is never taken as a result
    if (!resetn_i) begin
      meas_time_o <= 16'h5a5a;
      fe_cnt <= 3'h0;
    end else if (!meas_req_i || meas_done_o) begin
      fe_cnt <= 3'h0;
    end else if (fe_cnt == 3'h3) begin
      meas_done_o <= 1'b1;
      meas_time_o <= (cap_i == 2'h1) ? 16'h0100 : (cap_i == 2'h2) ? 16'h0300 :
                     (cap_i == 2'h3) ? 16'h0080 : 16'h0040;
    end else begin
      fe_cnt <= fe_cnt + 3'h1;
    end
  end
  // Processing ends three cycles after completion; host reads after the interrupt
  always_ff @(posedge clk_i) begin
    dsp_q <= resetn_i ? {dsp_q[0], eoc_i} : 2'h0;
    dsp_done_o <= resetn_i && dsp_q[1];
    int_n_q <= resetn_i ? int_n_i : 1'b1;
    rd_start_o <= host_q == 4'h4;
    rd_done_o <= host_q == 4'h8;
    if (!resetn_i || host_q == 4'h8) host_q <= 4'h0;
    else if (int_n_q && !int_n_i) host_q <= 4'h1;
    else if (host_q != 4'h0) host_q <= host_q + 4'h1;
  end
endmodule // cdcseq_far_model
`default_nettype wire

// ---- bench/cdcseq_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
// --------------------------------------------------
// Port checks of the conversion sequencer
// --------------------------------------------------
module cdcseq_monitor (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic SIF_READ_START_I,
  input wire logic MEAS_DONE_I,
  input wire logic MEAS_REQ_O,
  input wire logic [1:0] PORT_SW_O,
  input wire logic [1:0] CAP_PORT_CHG_O,
  input wire logic EOC_DSP_O,
  input wire logic EOC_RDC_O,
  input wire logic INTERRUPT_OUT_N_O
);
  // One clock domain, so clock and reset are stated once
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  AST_EOC_BOTH: assert property ((EOC_DSP_O || EOC_RDC_O) |-> (EOC_DSP_O && EOC_RDC_O))
    else $error("completion flags differ");
  AST_EOC_PULSE: assert property (EOC_DSP_O |=> !EOC_DSP_O)
    else $error("completion flag longer than one cycle");
  AST_INT_SET: assert property (EOC_DSP_O |-> !INTERRUPT_OUT_N_O)
    else $error("interrupt not low at completion");
  AST_INT_CAUSE: assert property ($fell(INTERRUPT_OUT_N_O) |-> EOC_DSP_O)
    else $error("interrupt fell without completion");
  AST_INT_FREE: assert property (SIF_READ_START_I |=> INTERRUPT_OUT_N_O || EOC_DSP_O)
    else $error("interrupt not released by read start");
  AST_STEP_END: assert property (MEAS_DONE_I && MEAS_REQ_O |=>
    !MEAS_REQ_O && PORT_SW_O == 2'b00 && CAP_PORT_CHG_O == 2'b00)
    else $error("step not closed after done");
  AST_INT_OPEN: assert property (MEAS_REQ_O && CAP_PORT_CHG_O == 2'b00 |-> PORT_SW_O == 2'b00)
    else $error("switch closed in internal step");
  AST_STEP_HOLD: assert property (MEAS_REQ_O && $past(MEAS_REQ_O) && !MEAS_DONE_I |=>
    MEAS_REQ_O && $stable(CAP_PORT_CHG_O) && $stable(PORT_SW_O))
    else $error("step dropped before done");
  // Main scenarios seen at the ports
  cover property (EOC_DSP_O);
  cover property (MEAS_REQ_O && CAP_PORT_CHG_O == 2'b11);
  cover property (SIF_READ_START_I && !INTERRUPT_OUT_N_O);
endmodule // cdcseq_monitor
bind cdcseq_top cdcseq_monitor cdcseq_monitor_inst (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
  .SIF_READ_START_I(SIF_READ_START_I), .MEAS_DONE_I(MEAS_DONE_I), .MEAS_REQ_O(MEAS_REQ_O),
  .PORT_SW_O(PORT_SW_O), .CAP_PORT_CHG_O(CAP_PORT_CHG_O), .EOC_DSP_O(EOC_DSP_O),
  .EOC_RDC_O(EOC_RDC_O), .INTERRUPT_OUT_N_O(INTERRUPT_OUT_N_O));
`default_nettype wire

// ---- pkg/cdcseq_pkg.sv ----
`default_nettype none
// -----------------------------------------------------------------------------
// Shared constants of the conversion sequencer
// -----------------------------------------------------------------------------
package cdcseq_pkg;

  // Register byte addresses (word aligned)
  localparam logic [7:0] CDCS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CDCS_ADDR_AVG = 8'h04;
  localparam logic [7:0] CDCS_ADDR_PERIOD = 8'h08;
  localparam logic [7:0] CDCS_ADDR_CMD = 8'h0c;
  localparam logic [7:0] CDCS_ADDR_STATUS = 8'h10;
  localparam logic [7:0] CDCS_ADDR_RESULT = 8'h14;
  localparam logic [7:0] CDCS_ADDR_INTDLY = 8'h18;
  // Gain correction sits at register index 35, four bytes per index
  localparam logic [7:0] CDCS_GAIN_IDX = 8'h23;
  localparam logic [7:0] CDCS_ADDR_GAIN = 8'(CDCS_GAIN_IDX * 8'h04);

  // Control register field positions
  localparam int CDCS_TRIG_LSB = 0;
  localparam int CDCS_DCFREE_BIT = 3;
  localparam int CDCS_CINT_BIT = 4;
  localparam int CDCS_CEXT_BIT = 5;
  localparam int CDCS_FLOAT_BIT = 6;
  localparam int CDCS_HFSEL_BIT = 7;
  localparam int CDCS_DIVBYP_BIT = 8;
  localparam int CDCS_DUMMY_LSB = 12;
  // Command register bits
  localparam int CDCS_CMD_START_BIT = 0;

  // Reset values
  localparam logic [2:0] CDCS_TRIG_RST = 3'h0;
  localparam logic CDCS_CINT_RST = 1'b1;
  localparam logic [3:0] CDCS_DUMMY_RST = 4'h0;
  localparam logic [12:0] CDCS_AVG_RST = 13'h0000;
  localparam logic [15:0] CDCS_PERIOD_RST = 16'h0000;
  localparam logic [7:0] CDCS_GAIN_RST = 8'h00;

  // Last high-frequency divider count (divide by four) for the fast/4 cycle base
  localparam logic [1:0] CDCS_HF_DIV_LAST = 2'h3;

  // Trigger source encodings
  typedef enum logic [2:0] {
    CDCS_TRIG_CONT = 3'h0,
    CDCS_TRIG_READ = 3'h1,
    CDCS_TRIG_TIMER = 3'h2,
    CDCS_TRIG_TIMER_STR = 3'h3,
    CDCS_TRIG_UNDEF = 3'h4,
    CDCS_TRIG_PIN = 3'h5,
    CDCS_TRIG_OPCODE = 3'h6,
    CDCS_TRIG_CONT_EXP = 3'h7
  } cdcs_trig_t;

  // Sequencer states
  typedef enum logic [2:0] {
    CDCS_IDLE,
    CDCS_ARM,
    CDCS_MEAS,
    CDCS_DSP
  } cdcs_state_t;

  // Discharge steps of one sequence
  typedef enum logic [1:0] {
    CDCS_STEP_P0,
    CDCS_STEP_P1,
    CDCS_STEP_BOTH,
    CDCS_STEP_INT
  } cdcs_step_t;

endpackage
`default_nettype wire

// ---- pkg/cdcseq_time_if.sv ----
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------------------------------------------
// Time base and conversion timer signals between sequencer modules
// -----------------------------------------------------------------------------
interface cdcseq_time_if;
  logic lf_tick;
  logic hf_tick;
  logic hf_sel;
  logic div_bypass;
  logic cycle_tick;
  logic timer_en;
  logic [15:0] period;
  logic timer_fire;

  modport tbase_mp (input lf_tick, hf_tick, hf_sel, div_bypass, output cycle_tick);
  modport timer_mp (input lf_tick, timer_en, period, output timer_fire);
  modport ctrl_mp (output lf_tick, hf_tick, hf_sel, div_bypass, timer_en, period,
                   input cycle_tick, timer_fire);
endinterface
`default_nettype wire

// ---- src/cdcseq_ctimer.sv ----
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------------------------------------------
// Conversion timer: fires every 2 * period low-frequency periods
// -----------------------------------------------------------------------------
module cdcseq_ctimer
  import cdcseq_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  cdcseq_time_if.timer_mp t
);

  typedef struct packed {
    logic [16:0] cnt;
    logic fire;
  } cdcs_tm_st_t;

  cdcs_tm_st_t s_q, s_d;

  assign t.timer_fire = s_q.fire;

  // Runs from reset whenever enabled; disabling parks the count at zero
  always_comb begin
    s_d = s_q;
    s_d.fire = 1'b0;
    if (!t.timer_en) begin
      s_d.cnt = '0;
    end else if (t.lf_tick) begin
      if (s_q.cnt + 17'h1 >= {t.period, 1'b0}) begin
        s_d.cnt = '0;
        s_d.fire = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 17'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // cdcseq_ctimer
`default_nettype wire

// ---- src/cdcseq_tbase.sv ----
`timescale 1ns/1ns
`default_nettype none
// -----------------------------------------------------------------------------
// Cycle time base: low-frequency period, four or one high-frequency periods
// -----------------------------------------------------------------------------
module cdcseq_tbase
  import cdcseq_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  cdcseq_time_if.tbase_mp t
);

  typedef struct packed {
    logic [1:0] div;
    logic tick;
  } cdcs_tb_st_t;

  cdcs_tb_st_t s_q, s_d;

  assign t.cycle_tick = s_q.tick;

  // Pick the tick source; divider only advances on high-frequency ticks
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!t.hf_sel) begin
      s_d.tick = t.lf_tick;
      s_d.div = 2'h0;
    end else if (t.div_bypass) begin
      s_d.tick = t.hf_tick;
      s_d.div = 2'h0;
    end else if (t.hf_tick) begin
      s_d.tick = (s_q.div == CDCS_HF_DIV_LAST);
      s_d.div = s_q.div + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // cdcseq_tbase
`default_nettype wire

// ---- src/cdcseq_top.sv ----
// Overview of operation
// - Triggered conversion runs to completion unattended
// - Completion flagged to DSP and resistance unit
// - Mode 0: auto start, restart on DSP done
// - Mode 1: first conversion started by host command
// - Completion pulls interrupt output low
// - Mode 1: finished result read starts next
// - Mode 2: internal timer starts conversions periodically
// - Mode 6: opcode starts conversion; mode 5: pin event starts it
// - Internal compensation step opens both port switches
// - External compensation: port 0, port 1, both
// - DC-free drive leaves idle floating port open
// - Internal delay subtracted from sensor result
// - Gain factor register 35, (factor-1)*256
// - Cycle base: slow oscillator, fast/4, fast
// - Trigger select encodings 0 to 7
// - Timer period is 2 * period slow periods
// - Dummy cycles 0..15, averaging up to 8191
//
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module cdcseq_top
  import cdcseq_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // AHB-Lite slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  // Oscillators and trigger pin (asynchronous)
  input wire logic LF_OSC_I,
  input wire logic HF_OSC_I,
  input wire logic START_PIN_I,
  // Serial host interface events (same clock)
  input wire logic SIF_START_CMD_I,
  input wire logic SIF_READ_START_I,
  input wire logic SIF_READ_DONE_I,
  // Discharge-time front end
  output logic MEAS_REQ_O,
  output logic [1:0] PORT_SW_O,
  output logic [1:0] CAP_PORT_CHG_O,
  input wire logic MEAS_DONE_I,
  input wire logic [15:0] MEAS_TIME_I,
  // DSP and resistance unit
  output logic EOC_DSP_O,
  output logic EOC_RDC_O,
  input wire logic DSP_DONE_I,
  output logic [31:0] RESULT_O,
  output logic [7:0] GAIN_CORR_O,
  output logic INTERRUPT_OUT_N_O
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    // Configuration
    logic [2:0] trig;
    logic dcfree, cint, cext, flt, hfsel, divbyp;
    logic [3:0] dummy;
    logic [12:0] avg;
    logic [15:0] period;
    logic [7:0] gain;
    // Bus
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic cmd_start;
    // Synchronisers
    logic [2:0] lf_s, hf_s, pin_s;
    // Sequencer
    cdcs_state_t st;
    cdcs_step_t step;
    logic started;
    logic [3:0] dcnt;
    logic [12:0] scnt;
    logic [31:0] acc;
    logic [15:0] t_p1, t_int;
    logic [31:0] result;
    logic [15:0] conv_cnt;
    logic meas_req;
    logic [1:0] sw, chg;
    logic eoc, int_n;
  } cdcs_top_st_t;

  cdcs_top_st_t s_q, s_d;

  cdcseq_time_if tif();

  // ---------------------------------------------------------------------------
  // Time base and conversion timer
  // ---------------------------------------------------------------------------
  // Ticks are rising edges of the synchronised oscillators, never stage one
  assign tif.lf_tick = s_q.lf_s[1] & ~s_q.lf_s[2];
  assign tif.hf_tick = s_q.hf_s[1] & ~s_q.hf_s[2];
  assign tif.hf_sel = s_q.hfsel;
  assign tif.div_bypass = s_q.divbyp;
  assign tif.period = s_q.period;
  // Timer only in the timer modes with a non-zero period
  assign tif.timer_en = ((s_q.trig == CDCS_TRIG_TIMER) || (s_q.trig == CDCS_TRIG_TIMER_STR))
                        && (s_q.period != 16'h0000);

  cdcseq_tbase cdcseq_tbase_inst (.clk_i(CLK_I), .resetn_i(RESETN_I), .t(tif.tbase_mp));

  cdcseq_ctimer cdcseq_ctimer_inst (.clk_i(CLK_I), .resetn_i(RESETN_I), .t(tif.timer_mp));

  // ---------------------------------------------------------------------------
  // Outputs, straight from the state register except the constant ready and response
  // ---------------------------------------------------------------------------
  assign HRDATA_O = s_q.rdata;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;
  assign MEAS_REQ_O = s_q.meas_req;
  assign PORT_SW_O = s_q.sw;
  assign CAP_PORT_CHG_O = s_q.chg;
  assign EOC_DSP_O = s_q.eoc;
  assign EOC_RDC_O = s_q.eoc;
  assign RESULT_O = s_q.result;
  assign GAIN_CORR_O = s_q.gain;
  assign INTERRUPT_OUT_N_O = s_q.int_n;

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  logic ap_take, wr_now, go, pin_rise, seq_end;
  logic [15:0] sample;
  logic [13:0] target;

  always_comb begin
    s_d = s_q;
    s_d.eoc = 1'b0;
    s_d.cmd_start = 1'b0;
    go = 1'b0;
    seq_end = 1'b0;
    sample = 16'h0000;
    target = (s_q.avg == 13'h0000) ? 14'h0001 : {1'b0, s_q.avg};

    // Synchronisers: stage one feeds stage two only
    s_d.lf_s = {s_q.lf_s[1:0], LF_OSC_I};
    s_d.hf_s = {s_q.hf_s[1:0], HF_OSC_I};
    s_d.pin_s = {s_q.pin_s[1:0], START_PIN_I};
    pin_rise = s_q.pin_s[1] & ~s_q.pin_s[2];

    // Bus address phase is captured; the data phase does the write
    ap_take = HSEL_I & HTRANS_I[1] & HREADY_I;
    wr_now = s_q.ap_wr;
    s_d.ap_wr = ap_take & HWRITE_I;
    if (ap_take) begin
      s_d.ap_addr = HADDR_I[7:0];
    end
    if (wr_now) begin
      unique case (s_q.ap_addr)
        CDCS_ADDR_CTRL: begin
          s_d.trig = HWDATA_I[CDCS_TRIG_LSB +: 3];
          s_d.dcfree = HWDATA_I[CDCS_DCFREE_BIT];
          s_d.cint = HWDATA_I[CDCS_CINT_BIT];
          s_d.cext = HWDATA_I[CDCS_CEXT_BIT];
          s_d.flt = HWDATA_I[CDCS_FLOAT_BIT];
          s_d.hfsel = HWDATA_I[CDCS_HFSEL_BIT];
          s_d.divbyp = HWDATA_I[CDCS_DIVBYP_BIT];
          s_d.dummy = HWDATA_I[CDCS_DUMMY_LSB +: 4];
          s_d.started = 1'b0;
        end
        CDCS_ADDR_AVG: s_d.avg = HWDATA_I[12:0];
        CDCS_ADDR_PERIOD: s_d.period = HWDATA_I[15:0];
        CDCS_ADDR_CMD: s_d.cmd_start = HWDATA_I[CDCS_CMD_START_BIT];
        CDCS_ADDR_GAIN: s_d.gain = HWDATA_I[7:0];
        default: ;
      endcase
    end
    // Read data prepared at the address phase, shown in the data phase
    s_d.rdata = 32'h0000_0000;
    if (ap_take && !HWRITE_I) begin
      unique case (HADDR_I[7:0])
        CDCS_ADDR_CTRL: s_d.rdata = {16'h0000, s_q.dummy, 3'h0, s_q.divbyp, s_q.hfsel,
                                     s_q.flt, s_q.cext, s_q.cint, s_q.dcfree, s_q.trig};
        CDCS_ADDR_AVG: s_d.rdata = {19'h00000, s_q.avg};
        CDCS_ADDR_PERIOD: s_d.rdata = {16'h0000, s_q.period};
        CDCS_ADDR_STATUS: s_d.rdata = {s_q.conv_cnt, 8'h00, s_q.int_n, s_q.started,
                                       s_q.step, 1'b0, s_q.st};
        CDCS_ADDR_RESULT: s_d.rdata = s_q.result;
        CDCS_ADDR_INTDLY: s_d.rdata = {16'h0000, s_q.t_int};
        CDCS_ADDR_GAIN: s_d.rdata = {24'h000000, s_q.gain};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    // Interrupt released when the host starts reading
    if (SIF_READ_START_I) begin
      s_d.int_n = 1'b1;
    end
    // Trigger selection; only looked at while idle, so busy triggers drop
    unique case (s_q.trig)
      CDCS_TRIG_CONT, CDCS_TRIG_CONT_EXP: go = 1'b1;
      CDCS_TRIG_READ: go = s_q.started ? SIF_READ_DONE_I
                                       : (SIF_START_CMD_I | s_q.cmd_start);
      CDCS_TRIG_TIMER, CDCS_TRIG_TIMER_STR: go = tif.timer_fire;
      CDCS_TRIG_PIN: go = pin_rise;
      CDCS_TRIG_OPCODE: go = SIF_START_CMD_I | s_q.cmd_start;
      default: go = 1'b0;
    endcase

    unique case (s_q.st)
      CDCS_IDLE: begin
        if (go) begin
          s_d.st = CDCS_ARM;
          s_d.step = CDCS_STEP_P0;
          s_d.started = 1'b1;
          s_d.dcnt = s_q.dummy;
          s_d.scnt = 13'h0000;
          s_d.acc = 32'h0000_0000;
          s_d.int_n = 1'b1;
          s_d.conv_cnt = s_q.conv_cnt + 16'h0001;
        end
      end
      CDCS_ARM: begin
        // Each discharge starts on a cycle time base tick
        if (tif.cycle_tick) begin
          s_d.st = CDCS_MEAS;
          s_d.meas_req = 1'b1;
          unique case (s_q.step)
            CDCS_STEP_P0: begin
              s_d.chg = 2'b01;
              s_d.sw = {~(s_q.dcfree & s_q.flt), 1'b1};
            end
            CDCS_STEP_P1: begin
              s_d.chg = 2'b10;
              s_d.sw = {1'b1, ~(s_q.dcfree & s_q.flt)};
            end
            CDCS_STEP_BOTH: begin
              s_d.chg = 2'b11;
              s_d.sw = 2'b11;
            end
            CDCS_STEP_INT: begin
              s_d.chg = 2'b00;
              s_d.sw = 2'b00;
            end
          endcase
        end
      end
      CDCS_MEAS: begin
        if (MEAS_DONE_I) begin
          s_d.meas_req = 1'b0;
          s_d.sw = 2'b00;
          s_d.chg = 2'b00;
          s_d.st = CDCS_ARM;
          unique case (s_q.step)
            CDCS_STEP_P0: s_d.step = CDCS_STEP_P1;
            CDCS_STEP_P1: begin
              s_d.t_p1 = MEAS_TIME_I;
              if (s_q.flt && s_q.cext) begin
                s_d.step = CDCS_STEP_BOTH;
              end else if (s_q.cint) begin
                s_d.step = CDCS_STEP_INT;
              end else begin
                seq_end = 1'b1;
              end
            end
            CDCS_STEP_BOTH: begin
              if (s_q.cint) begin
                s_d.step = CDCS_STEP_INT;
              end else begin
                seq_end = 1'b1;
              end
            end
            CDCS_STEP_INT: begin
              s_d.t_int = MEAS_TIME_I;
              seq_end = 1'b1;
            end
          endcase
        end
      end
      CDCS_DSP: begin
        // Hold off new triggers until post-processing is done
        if (DSP_DONE_I) begin
          s_d.st = CDCS_IDLE;
        end
      end
      default: s_d.st = CDCS_IDLE;
    endcase

    // End of one sequence: discard dummies, then accumulate real samples
    if (seq_end) begin
      if (s_q.cint && (s_q.step == CDCS_STEP_INT)) begin
        sample = (MEAS_TIME_I > s_q.t_p1) ? 16'h0000 : s_q.t_p1 - MEAS_TIME_I;
      end else begin
        sample = (s_q.step == CDCS_STEP_P1) ? MEAS_TIME_I : s_q.t_p1;
      end
      s_d.step = CDCS_STEP_P0;
      if (s_q.dcnt != 4'h0) begin
        s_d.dcnt = s_q.dcnt - 4'h1;
      end else begin
        s_d.acc = s_q.acc + {16'h0000, sample};
        s_d.scnt = s_q.scnt + 13'h0001;
        if ({1'b0, s_q.scnt} + 14'h0001 >= target) begin
          s_d.result = s_q.acc + {16'h0000, sample};
          s_d.eoc = 1'b1;
          s_d.int_n = 1'b0;
          s_d.st = CDCS_DSP;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // A single reset image keeps configuration and sequencer consistent
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      s_q <= '0;
      s_q.trig <= CDCS_TRIG_RST;
      s_q.cint <= CDCS_CINT_RST;
      s_q.dummy <= CDCS_DUMMY_RST;
      s_q.avg <= CDCS_AVG_RST;
      s_q.period <= CDCS_PERIOD_RST;
      s_q.gain <= CDCS_GAIN_RST;
      s_q.int_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

endmodule // cdcseq_top
`default_nettype wire
